// ===== src/ise_defines.vh
// constants for the instruction semantics unit
`ifndef ISE_DEFINES_VH
`define ISE_DEFINES_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define ISE_OFF_CTRL    12'h000
`define ISE_OFF_SRC     12'h004
`define ISE_OFF_DST     12'h008
`define ISE_OFF_AUX     12'h00c
`define ISE_OFF_RES     12'h010
`define ISE_OFF_RESHI   12'h014
`define ISE_OFF_STAT    12'h018
`define ISE_OFF_SP      12'h01c
`define ISE_OFF_SW      12'h020
`define ISE_OFF_SPACE   12'h024
`define ISE_OFF_MMUREG  12'h028
`define ISE_OFF_TSTAT   12'h02c
`define ISE_OFF_TCACHE  12'h030

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define ISE_CTRL_OP_LSB   0
`define ISE_CTRL_OP_MSB   4
`define ISE_CTRL_SZ_LSB   8
`define ISE_CTRL_SZ_MSB   9
`define ISE_CTRL_DIR_BIT  12
`define ISE_CTRL_CNT_LSB  16
`define ISE_CTRL_CNT_MSB  21

// ------------------------------------------------------------
// operation codes
// ------------------------------------------------------------
`define ISE_OP_NOP     5'h00
`define ISE_OP_ALT_SPACE_MOVE   5'h01
`define ISE_OP_MULT_SIGNED    5'h02
`define ISE_OP_MULT_UNSIGNED    5'h03
`define ISE_OP_DECIMAL_NEGATE    5'h04
`define ISE_OP_NEG     5'h05
`define ISE_OP_NEGATE_WITH_EXTEND    5'h06
`define ISE_OP_NOT     5'h07
`define ISE_OP_OR      5'h08
`define ISE_OP_ORI     5'h09
`define ISE_OP_ORICCR  5'h0a
`define ISE_OP_ORISW   5'h0b
`define ISE_OP_PEA     5'h0c
`define ISE_OP_FLUSH   5'h0d
`define ISE_OP_LOAD    5'h0e
`define ISE_OP_MMOVE   5'h0f
`define ISE_OP_PROBE   5'h10
`define ISE_OP_RESET   5'h11
`define ISE_OP_ROT     5'h12
`define ISE_OP_ROTX    5'h13

// ------------------------------------------------------------
// operand sizes, flags, reset values, timing
// ------------------------------------------------------------
`define ISE_SZ_BYTE    2'h0
`define ISE_SZ_WORD    2'h1
`define ISE_SZ_LONG    2'h2
`define ISE_SZ_PAIR    2'h3
`define ISE_SW_S_BIT   13
`define ISE_SW_X_BIT   4
`define ISE_SW_RST     16'h2700
`define ISE_SP_RST     32'h0000_1000
`define ISE_PEA_DEC    32'h0000_0004
`define ISE_RESET_OUT_LINE_NS    1000
`define ISE_RESET_OUT_LINE_CYC   ((`ISE_RESET_OUT_LINE_NS + 9) / 10)

`endif

// ===== src/ise_core.v
// instruction semantics unit with apb register access
// Behaviour
// [RULE1] supervisor alternate-space move uses dest or src space code; user traps
// [RULE2] multiply: word to 32-bit, long to 32-bit, long to high:low pair
// [RULE3] signed multiply is two's complement, unsigned multiply is magnitude
// [RULE4] decimal negate computes zero minus destination minus extend in bcd
// [RULE5] binary negate writes zero minus destination
// [RULE6] negate with extend writes zero minus destination minus extend
// [RULE7] complement inverts every destination bit
// [RULE8] or combines source and destination, either direction
// [RULE9] or-immediate ors immediate data into destination
// [RULE10] or to condition codes always; to status word only supervisor
// [RULE11] push address: stack pointer minus four, then store the address
// [RULE12] supervisor flush invalidates matching cache entries; user traps
// [RULE13] supervisor load creates a cache entry; user traps, loads nothing
// [RULE14] supervisor mmu register move copies in or out
// [RULE15] supervisor probe writes status and loads entry; user traps
// [RULE16] supervisor reset pulses the external reset line; user traps
// [RULE17] plain rotate left or right by count, extend not included
// [RULE18] rotate through extend includes extend in the path
// [RULE19] no-operation changes no state
// [RULE20] privileged op in user state traps before any state change
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "ise_defines.vh"

module ise_core #(
  parameter ENTRIES = 4,
  parameter RST_CYC = `ISE_RESET_OUT_LINE_CYC
) (
  // apb clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // device side effects
  output reg         reset_out_line,
  output reg         priv_trap,
  output reg         mem_wr,
  output reg  [31:0] mem_addr,
  output reg  [31:0] mem_wdata,
  output reg  [2:0]  mem_space
);

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  localparam S_IDLE = 2'b01;
  localparam S_RST  = 2'b10;

  reg [1:0]  st_q;
  reg [31:0] ctrl_q, src_q, dst_q, aux_q, res_q, reshi_q, sp_q;
  reg [15:0] sw_q;
  reg [5:0]  space_q;
  reg [31:0] mmureg_q, tstat_q;
  reg [31:0] tag_q [0:ENTRIES-1];
  reg [ENTRIES-1:0] vld_q;
  reg [15:0] rcnt_q;
  reg [1:0]  ptr_q;

  wire wr  = psel & penable & pwrite;
  wire rd  = psel & penable & ~pwrite;
  wire go  = wr & (paddr == `ISE_OFF_CTRL);
  wire [4:0] op  = pwdata[`ISE_CTRL_OP_MSB:`ISE_CTRL_OP_LSB];
  wire [1:0] sz  = pwdata[`ISE_CTRL_SZ_MSB:`ISE_CTRL_SZ_LSB];
  wire       dir = pwdata[`ISE_CTRL_DIR_BIT];
  wire [5:0] cnt = pwdata[`ISE_CTRL_CNT_MSB:`ISE_CTRL_CNT_LSB];
  wire       sup = sw_q[`ISE_SW_S_BIT];
  wire       xf  = sw_q[`ISE_SW_X_BIT];

  function is_priv;
    input [4:0] o;
    begin
      is_priv = (o == `ISE_OP_ALT_SPACE_MOVE) | (o == `ISE_OP_ORISW) |
                (o == `ISE_OP_FLUSH) | (o == `ISE_OP_LOAD) |
                (o == `ISE_OP_MMOVE) | (o == `ISE_OP_PROBE) |
                (o == `ISE_OP_RESET);
    end
  endfunction

  // size mask of the destination operand
  function [31:0] szmask;
    input [1:0] s;
    begin
      case (s)
        `ISE_SZ_BYTE: szmask = 32'h0000_00ff;
        `ISE_SZ_WORD: szmask = 32'h0000_ffff;
        default:      szmask = 32'hffff_ffff;
      endcase
    end
  endfunction

  wire trap = is_priv(op) & ~sup; // RULE20

  // ----------------------------------------------------------
  // multiply
  // ----------------------------------------------------------
  wire signed [63:0] ps_l = $signed(src_q) * $signed(dst_q); // RULE3
  wire        [63:0] pu_l = {32'h0, src_q} * {32'h0, dst_q}; // RULE3
  wire signed [31:0] ps_w = $signed(src_q[15:0]) * $signed(dst_q[15:0]);
  wire        [31:0] pu_w = src_q[15:0] * dst_q[15:0];

  // ----------------------------------------------------------
  // bcd negate of one byte
  // ----------------------------------------------------------
  reg [7:0] bcd_r;
  reg [4:0] lo_t;
  reg [4:0] hi_t;
  reg       bcd_b;
  // the low digit's borrow runs into the high digit; a digit that borrowed is corrected by six
  always @* begin
    lo_t = 5'h00 - {1'b0, dst_q[3:0]} - {4'h0, xf};
    bcd_b = lo_t[4];
    if (lo_t[4])
      lo_t = lo_t - 5'h06;
    hi_t = 5'h00 - {1'b0, dst_q[7:4]} - {4'h0, bcd_b};
    if (hi_t[4])
      hi_t = hi_t - 5'h06;
    bcd_r = {hi_t[3:0], lo_t[3:0]}; // RULE4
  end

  // ----------------------------------------------------------
  // rotate within the operand size, optional extend in path
  // ----------------------------------------------------------
  reg [31:0] rot_v;
  reg        rot_x;
  reg        rot_b;
  reg        rot_in;
  reg [31:0] rot_m;
  integer    i;
  reg [5:0]  w;
  // the size comes from the control word being written; ctrl_q still
  // holds the previous command in this cycle
  always @* begin
    rot_m = szmask(sz);
    w = (sz == `ISE_SZ_BYTE) ? 6'd8 :
        (sz == `ISE_SZ_WORD) ? 6'd16 : 6'd32;
    rot_v = dst_q & rot_m;
    rot_x = xf;
    rot_b = 1'b0;
    rot_in = 1'b0;
    for (i = 0; i < 63; i = i + 1) begin
      if (i < cnt) begin
        // bit that leaves the operand in this step
        rot_b = dir ? rot_v[0] : rot_v[w-1];
        // through extend, the old extend bit enters instead
        rot_in = (op == `ISE_OP_ROTX) ? rot_x : rot_b; // RULE18
        if (!dir)
          rot_v = ((rot_v << 1) | {31'h0, rot_in}) & rot_m; // RULE17
        else
          rot_v = ((rot_v >> 1) | ({31'h0, rot_in} << (w - 6'd1))) &
                  rot_m; // RULE17
        if (op == `ISE_OP_ROTX)
          rot_x = rot_b; // RULE18
      end
    end
  end

  // ----------------------------------------------------------
  // execute and register writes
  // ----------------------------------------------------------
  genvar g;
  wire [ENTRIES-1:0] hit;
  generate
    for (g = 0; g < ENTRIES; g = g + 1) begin : g_hit
      assign hit[g] = vld_q[g] & (tag_q[g] == dst_q);
    end
  endgenerate

  integer k;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_IDLE;
      ctrl_q <= 32'h0; src_q <= 32'h0; dst_q <= 32'h0; aux_q <= 32'h0;
      res_q <= 32'h0; reshi_q <= 32'h0; sp_q <= `ISE_SP_RST;
      sw_q <= `ISE_SW_RST; space_q <= 6'h00;
      mmureg_q <= 32'h0; tstat_q <= 32'h0;
      vld_q <= {ENTRIES{1'b0}}; rcnt_q <= 16'h0; ptr_q <= 2'h0;
      for (k = 0; k < ENTRIES; k = k + 1)
        tag_q[k] <= 32'h0;
      reset_out_line <= 1'b0; priv_trap <= 1'b0;
      mem_wr <= 1'b0; mem_addr <= 32'h0; mem_wdata <= 32'h0;
      mem_space <= 3'h0;
    end else begin
      priv_trap <= 1'b0;
      mem_wr <= 1'b0;
      if (st_q == S_RST) begin
        if (rcnt_q == 16'h1) begin
          reset_out_line <= 1'b0;
          st_q <= S_IDLE;
        end
        rcnt_q <= rcnt_q - 16'h1;
      end
      if (wr) begin
        case (paddr)
          `ISE_OFF_SRC:    src_q <= pwdata;
          `ISE_OFF_DST:    dst_q <= pwdata;
          `ISE_OFF_AUX:    aux_q <= pwdata;
          `ISE_OFF_SP:     sp_q <= pwdata;
          `ISE_OFF_SW:     sw_q <= pwdata[15:0];
          `ISE_OFF_SPACE:  space_q <= pwdata[5:0];
          default: ;
        endcase
      end
      if (go) begin
        ctrl_q <= pwdata;
        if (trap)
          priv_trap <= 1'b1; // RULE20
        else begin
          case (op)
            `ISE_OP_ALT_SPACE_MOVE: begin
              if (dir) begin
                mem_wr <= 1'b1; mem_addr <= aux_q; mem_wdata <= src_q;
                mem_space <= space_q[2:0]; // RULE1
              end else begin
                res_q <= dst_q; mem_space <= space_q[5:3]; // RULE1
              end
            end
            `ISE_OP_MULT_SIGNED: begin
              if (sz == `ISE_SZ_WORD) res_q <= ps_w; // RULE2
              else res_q <= ps_l[31:0];
              if (sz == `ISE_SZ_PAIR) reshi_q <= ps_l[63:32]; // RULE2
            end
            `ISE_OP_MULT_UNSIGNED: begin
              if (sz == `ISE_SZ_WORD) res_q <= pu_w; // RULE2
              else res_q <= pu_l[31:0];
              if (sz == `ISE_SZ_PAIR) reshi_q <= pu_l[63:32];
            end
            `ISE_OP_DECIMAL_NEGATE: begin
              res_q <= {24'h0, bcd_r}; // RULE4
              sw_q[`ISE_SW_X_BIT] <= (dst_q[7:0] != 8'h00) | xf;
            end
            `ISE_OP_NEG: begin
              res_q <= (32'h0 - dst_q) & szmask(sz); // RULE5
              sw_q[`ISE_SW_X_BIT] <= |(dst_q & szmask(sz));
            end
            `ISE_OP_NEGATE_WITH_EXTEND: begin
              res_q <= (32'h0 - dst_q - {31'h0, xf}) & szmask(sz); // RULE6
              sw_q[`ISE_SW_X_BIT] <= (|(dst_q & szmask(sz))) | xf;
            end
            `ISE_OP_NOT:  res_q <= ~dst_q & szmask(sz); // RULE7
            `ISE_OP_OR: begin
              res_q <= (src_q | dst_q) & szmask(sz); // RULE8
              if (dir) begin
                mem_wr <= 1'b1; mem_addr <= aux_q;
                mem_wdata <= (src_q | dst_q) & szmask(sz); // RULE8
              end
            end
            `ISE_OP_ORI:  res_q <= (src_q | dst_q) & szmask(sz); // RULE9
            `ISE_OP_ORICCR: sw_q[7:0] <= sw_q[7:0] | src_q[7:0]; // RULE10
            `ISE_OP_ORISW:  sw_q <= sw_q | src_q[15:0]; // RULE10
            // the address itself is stored, never the memory word at it
            `ISE_OP_PEA: begin
              sp_q <= sp_q - `ISE_PEA_DEC; // RULE11
              mem_wr <= 1'b1; mem_addr <= sp_q - `ISE_PEA_DEC;
              mem_wdata <= aux_q; // RULE11
            end
            `ISE_OP_FLUSH: vld_q <= vld_q & ~hit; // RULE12
            `ISE_OP_LOAD: begin
              if (hit == {ENTRIES{1'b0}}) begin
                tag_q[ptr_q] <= dst_q; vld_q[ptr_q] <= 1'b1; // RULE13
                ptr_q <= ptr_q + 2'h1;
              end
            end
            `ISE_OP_MMOVE: begin
              if (dir) begin
                mem_wr <= 1'b1; mem_addr <= aux_q;
                mem_wdata <= mmureg_q; // RULE14
              end else
                mmureg_q <= src_q; // RULE14
            end
            `ISE_OP_PROBE: begin
              tstat_q <= {31'h0, |hit}; // RULE15
              if (hit == {ENTRIES{1'b0}}) begin
                tag_q[ptr_q] <= dst_q; vld_q[ptr_q] <= 1'b1; // RULE15
                ptr_q <= ptr_q + 2'h1;
              end
            end
            // a reset command during a running pulse restarts the count
            `ISE_OP_RESET: begin
              reset_out_line <= 1'b1; // RULE16
              rcnt_q <= RST_CYC[15:0];
              st_q <= S_RST;
            end
            `ISE_OP_ROT:  res_q <= rot_v[31:0]; // RULE17
            `ISE_OP_ROTX: begin
              res_q <= rot_v[31:0]; // RULE18
              if (cnt != 6'h00) sw_q[`ISE_SW_X_BIT] <= rot_x;
            end
            default: ; // RULE19
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------
  // apb read path, zero wait states
  // ----------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0; pready <= 1'b0; pslverr <= 1'b0;
    end else begin
      // every setup is answered one cycle later, so the bus never waits
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `ISE_OFF_CTRL:   prdata <= ctrl_q;
          `ISE_OFF_SRC:    prdata <= src_q;
          `ISE_OFF_DST:    prdata <= dst_q;
          `ISE_OFF_AUX:    prdata <= aux_q;
          `ISE_OFF_RES:    prdata <= res_q;
          `ISE_OFF_RESHI:  prdata <= reshi_q;
          `ISE_OFF_STAT:   prdata <= {30'h0, reset_out_line, |vld_q};
          `ISE_OFF_SP:     prdata <= sp_q;
          `ISE_OFF_SW:     prdata <= {16'h0, sw_q};
          `ISE_OFF_SPACE:  prdata <= {26'h0, space_q};
          `ISE_OFF_MMUREG: prdata <= mmureg_q;
          `ISE_OFF_TSTAT:  prdata <= tstat_q;
          `ISE_OFF_TCACHE: prdata <= {{(32-ENTRIES){1'b0}}, vld_q};
          default:         pslverr <= 1'b1;
        endcase
      end else if (psel & ~penable & pwrite) begin
        case (paddr)
          `ISE_OFF_CTRL, `ISE_OFF_SRC, `ISE_OFF_DST, `ISE_OFF_AUX,
          `ISE_OFF_SP, `ISE_OFF_SW, `ISE_OFF_SPACE: pslverr <= 1'b0;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  wire unused_ok = rd;

endmodule

// ===== dv/ise_core_assertions.sv
// port-level concurrent checks for the instruction semantics unit
`timescale 1ns/100ps
`include "ise_defines.vh"

module ise_core_assertions #(
  parameter RST_CYC = 4
) (
  // apb side
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  // side effects
  input logic        reset_out_line,
  input logic        priv_trap,
  input logic        mem_wr,
  input logic [31:0] mem_addr,
  input logic [31:0] mem_wdata
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic        wr, ctrl_wr, rst_req, nop_req, pea_req, mv_req, ccr_req;
  logic [31:0] src_q, aux_q;
  int          hi_q;

  assign wr      = psel && penable && pwrite && pready;
  assign ctrl_wr = wr && paddr == `ISE_OFF_CTRL;
  assign rst_req = ctrl_wr && pwdata[4:0] == `ISE_OP_RESET;
  assign nop_req = ctrl_wr && pwdata[4:0] == `ISE_OP_NOP;
  assign pea_req = ctrl_wr && pwdata[4:0] == `ISE_OP_PEA;
  assign ccr_req = ctrl_wr && pwdata[4:0] == `ISE_OP_ORICCR;
  assign mv_req  = ctrl_wr && pwdata[4:0] == `ISE_OP_ALT_SPACE_MOVE && pwdata[12];

  // shadow operands so side effects can be tied to what software wrote
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= 32'h0;
      aux_q <= 32'h0;
      hi_q  <= 0;
    end else begin
      if (wr && paddr == `ISE_OFF_SRC) src_q <= pwdata;
      if (wr && paddr == `ISE_OFF_AUX) aux_q <= pwdata;
      hi_q <= reset_out_line ? hi_q + 1 : 0;
    end
  end

  property p_ready;
    psel && !penable |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_trap_clean;
    priv_trap |-> !mem_wr && !$rose(reset_out_line);
  endproperty
  a_trap_clean: assert property (p_trap_clean)
    else $error("trap came with a state change");
  property p_reset_out_line_cause;
    $rose(reset_out_line) |-> $past(rst_req) || $past(rst_req, 2);
  endproperty
  a_reset_out_line_cause: assert property (p_reset_out_line_cause)
    else $error("reset line rose without request");
  property p_reset_out_line_len;
    $fell(reset_out_line) |-> hi_q == RST_CYC;
  endproperty
  a_reset_out_line_len: assert property (p_reset_out_line_len)
    else $error("reset line pulse length wrong");
  property p_reset_out_line_max;
    reset_out_line |-> hi_q < RST_CYC;
  endproperty
  a_reset_out_line_max: assert property (p_reset_out_line_max)
    else $error("reset line held too long");
  property p_nop;
    nop_req |=> (!mem_wr && !priv_trap) [*2];
  endproperty
  a_nop: assert property (p_nop) else $error("idle op had an effect");
  property p_ccr;
    ccr_req |=> !priv_trap [*2];
  endproperty
  a_ccr: assert property (p_ccr) else $error("cond code or trapped");
  property p_pea;
    pea_req |-> ##[1:2] (mem_wr && mem_wdata == aux_q);
  endproperty
  a_pea: assert property (p_pea) else $error("push address not stored");
  property p_alt_space_move;
    mv_req |-> ##[1:2] (priv_trap ||
      (mem_wr && mem_wdata == src_q && mem_addr == aux_q));
  endproperty
  a_alt_space_move: assert property (p_alt_space_move)
    else $error("space move store wrong");

  c_pea: cover property (pea_req ##[1:2] mem_wr);
  c_trap: cover property (priv_trap);
  c_reset_out_line: cover property ($fell(reset_out_line));
endmodule

// ===== dv/ise_core_tb.sv
// self-checking bench for the instruction semantics unit
`timescale 1ns/100ps
`include "ise_defines.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end

module ise_core_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, mem_addr, mem_wdata, rd, s, d, w_addr, w_data;
  logic        pready, pslverr, reset_out_line, priv_trap, mem_wr, er, x, dr;
  logic [2:0]  mem_space, w_space;
  logic [4:0]  o;
  logic [1:0]  sz;
  logic [5:0]  c;
  logic [63:0] ex;
  int          n_errors = 0, checks = 0, n_trap = 0, n_wr = 0, n_rst = 0;
  int          t0, w0;
  logic [4:0]  alu_ops [10] = '{`ISE_OP_NEG, `ISE_OP_NEGATE_WITH_EXTEND, `ISE_OP_NOT,
    `ISE_OP_OR, `ISE_OP_ORI, `ISE_OP_MULT_SIGNED, `ISE_OP_MULT_UNSIGNED, `ISE_OP_ROT,
    `ISE_OP_ROTX, `ISE_OP_DECIMAL_NEGATE};
  logic [4:0]  priv_ops [7] = '{`ISE_OP_ALT_SPACE_MOVE, `ISE_OP_ORISW, `ISE_OP_ORICCR,
    `ISE_OP_FLUSH, `ISE_OP_LOAD, `ISE_OP_PROBE, `ISE_OP_RESET};

  ise_core #(.RST_CYC(4)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_out_line, .priv_trap,
    .mem_wr, .mem_addr, .mem_wdata, .mem_space);

  always #5 pclk = ~pclk;

  // ----
  // side-effect monitor
  // ----
  always @(posedge pclk) begin
    if (priv_trap === 1'b1) n_trap <= n_trap + 1;
    if (reset_out_line === 1'b1) n_rst <= n_rst + 1;
    if (mem_wr === 1'b1) begin
      n_wr    <= n_wr + 1;
      w_addr  <= mem_addr;
      w_data  <= mem_wdata;
      w_space <= mem_space;
    end
  end

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] v);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // side effects land within two edges of the control write
  task automatic run(input logic [4:0] op, input logic [1:0] z,
                     input logic r, input logic [5:0] n);
    xfer(1'b1, `ISE_OFF_CTRL, {10'h0, n, 3'h0, r, 2'h0, z, 3'h0, op});
    repeat (3) @(posedge pclk);
  endtask

  function automatic logic [63:0] model(input logic [4:0] op,
    input logic [1:0] z, input logic r, input logic [5:0] n,
    input logic [31:0] a, input logic [31:0] b, input logic xf);
    logic [32:0] t;
    logic [63:0] q;
    int          v;
    t = {xf, b};
    q = {32'h0, b};
    case (op)
      `ISE_OP_NEG:  q[31:0] = 32'h0 - b;
      `ISE_OP_NEGATE_WITH_EXTEND: q[31:0] = 32'h0 - b - 32'(xf);
      `ISE_OP_NOT:  q[31:0] = ~b;
      `ISE_OP_MULT_SIGNED: q = (z == `ISE_SZ_WORD) ?
        {{48{a[15]}}, a[15:0]} * {{48{b[15]}}, b[15:0]} :
        {{32{a[31]}}, a} * {{32{b[31]}}, b};
      `ISE_OP_MULT_UNSIGNED: q = (z == `ISE_SZ_WORD) ?
        {48'h0, a[15:0]} * {48'h0, b[15:0]} : {32'h0, a} * {32'h0, b};
      `ISE_OP_ROT:  repeat (n) q[31:0] = r ? {q[0], q[31:1]} : {q[30:0], q[31]};
      `ISE_OP_ROTX: begin
        repeat (n) t = r ? {t[0], t[32:1]} : {t[31:0], t[32]};
        q[31:0] = t[31:0];
      end
      `ISE_OP_DECIMAL_NEGATE: begin
        v = b[7:4] * 10 + b[3:0] + xf;
        v = v ? 100 - v : 0;
        q[7:0] = 8'((v / 10) * 16 + v % 10);
      end
      default: q[31:0] = a | b;
    endcase
    return q;
  endfunction

  task automatic wrap_up;
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h753e));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, `ISE_OFF_SW, 32'h0);
    `CHK(rd, {16'h0, `ISE_SW_RST})
    xfer(1'b0, `ISE_OFF_SP, 32'h0);
    `CHK(rd, `ISE_SP_RST)
    xfer(1'b1, 12'h040, 32'h1);
    `CHK(er, 1'b1)
    xfer(1'b1, `ISE_OFF_RES, 32'h1);
    `CHK(er, 1'b1)
    run(`ISE_OP_NOP, `ISE_SZ_LONG, 1'b0, 6'h0);
    `CHK(n_wr + n_trap, 0)
    $display("test reset_map done");
    for (int i = 0; i < 60; i++) begin
      o = alu_ops[i % 10];
      s = $urandom;
      d = $urandom;
      x = 1'($urandom);
      c = 6'($urandom);
      dr = (o == `ISE_OP_ROT || o == `ISE_OP_ROTX) ? 1'($urandom) : 1'b0;
      sz = (o == `ISE_OP_MULT_SIGNED || o == `ISE_OP_MULT_UNSIGNED) ?
        2'($urandom_range(3, 1)) : `ISE_SZ_LONG;
      if (o == `ISE_OP_DECIMAL_NEGATE) begin
        sz = `ISE_SZ_BYTE;
        d = {24'h0, 4'($urandom_range(9)), 4'($urandom_range(9))};
      end
      ex = model(o, sz, dr, c, s, d, x);
      xfer(1'b1, `ISE_OFF_SW, {16'h0, `ISE_SW_RST} | (32'(x) << 4));
      xfer(1'b1, `ISE_OFF_SRC, s);
      xfer(1'b1, `ISE_OFF_DST, d);
      run(o, sz, dr, c);
      xfer(1'b0, `ISE_OFF_RES, 32'h0);
      if (o == `ISE_OP_DECIMAL_NEGATE) `CHK(rd[7:0], ex[7:0])
      else `CHK(rd, ex[31:0])
      if (sz == `ISE_SZ_PAIR) begin
        xfer(1'b0, `ISE_OFF_RESHI, 32'h0);
        `CHK(rd, ex[63:32])
      end
    end
    $display("test alu done");
    xfer(1'b1, `ISE_OFF_SRC, 32'h11);
    for (int p = 0; p < 2; p++) begin
      xfer(1'b1, `ISE_OFF_SW, p ? 32'h0 : {16'h0, `ISE_SW_RST});
      foreach (priv_ops[j]) begin
        t0 = n_trap;
        w0 = n_wr;
        run(priv_ops[j], `ISE_SZ_LONG, 1'b0, 6'h0);
        `CHK(n_trap - t0, (p && priv_ops[j] != `ISE_OP_ORICCR) ? 1 : 0)
        `CHK(n_wr, w0)
      end
      xfer(1'b0, `ISE_OFF_SW, 32'h0);
      `CHK(rd, p ? 32'h11 : {16'h0, `ISE_SW_RST} | 32'h11)
    end
    `CHK(n_rst, 4)
    $display("test privilege done");
    xfer(1'b1, `ISE_OFF_SW, {16'h0, `ISE_SW_RST});
    s = $urandom;
    d = $urandom & 32'hffff_fffc;
    xfer(1'b1, `ISE_OFF_SP, d);
    xfer(1'b1, `ISE_OFF_AUX, s);
    run(`ISE_OP_PEA, `ISE_SZ_LONG, 1'b0, 6'h0);
    `CHK(w_data, s)
    `CHK(w_addr, d - `ISE_PEA_DEC)
    xfer(1'b0, `ISE_OFF_SP, 32'h0);
    `CHK(rd, d - `ISE_PEA_DEC)
    xfer(1'b1, `ISE_OFF_SPACE, 32'h15);
    xfer(1'b1, `ISE_OFF_SRC, d);
    run(`ISE_OP_ALT_SPACE_MOVE, `ISE_SZ_LONG, 1'b1, 6'h0);
    `CHK({w_space, w_addr, w_data}, {3'h5, s, d})
    $display("test stores done");
    xfer(1'b1, `ISE_OFF_DST, ~d);
    run(`ISE_OP_PROBE, `ISE_SZ_LONG, 1'b0, 6'h0);
    xfer(1'b0, `ISE_OFF_TSTAT, 32'h0);
    `CHK(rd, 32'h0)
    xfer(1'b0, `ISE_OFF_TCACHE, 32'h0);
    `CHK(rd, 32'h3)
    run(`ISE_OP_PROBE, `ISE_SZ_LONG, 1'b0, 6'h0);
    xfer(1'b0, `ISE_OFF_TSTAT, 32'h0);
    `CHK(rd, 32'h1)
    run(`ISE_OP_LOAD, `ISE_SZ_LONG, 1'b0, 6'h0);
    run(`ISE_OP_FLUSH, `ISE_SZ_LONG, 1'b0, 6'h0);
    xfer(1'b0, `ISE_OFF_TCACHE, 32'h0);
    `CHK(rd, 32'h1)
    run(`ISE_OP_LOAD, `ISE_SZ_LONG, 1'b0, 6'h0);
    xfer(1'b0, `ISE_OFF_TCACHE, 32'h0);
    `CHK(rd, 32'h5)
    run(`ISE_OP_MMOVE, `ISE_SZ_LONG, 1'b0, 6'h0);
    xfer(1'b0, `ISE_OFF_MMUREG, 32'h0);
    `CHK(rd, d)
    run(`ISE_OP_MMOVE, `ISE_SZ_LONG, 1'b1, 6'h0);
    `CHK({w_addr, w_data}, {s, d})
    $display("test translation done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, `ISE_OFF_TCACHE, 32'h0);
    `CHK(rd, 32'h0)
    xfer(1'b0, `ISE_OFF_SW, 32'h0);
    `CHK(rd, {16'h0, `ISE_SW_RST})
    $display("test mid reset done");
    wrap_up();
  end
endmodule

bind ise_core ise_core_assertions #(.RST_CYC(RST_CYC)) u_chk (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .reset_out_line, .priv_trap, .mem_wr, .mem_addr, .mem_wdata);
